/* include/rxs_pkg.sv */
// rxs_pkg: constants and types shared by the reset and exception sequencer
package rxs_pkg;

   // sequencer states
   typedef enum logic [2:0] {
      ST_RUN    = 3'b000,
      ST_LONG   = 3'b001,
      ST_PINLOW = 3'b010,
      ST_HOLD   = 3'b011,
      ST_TAIL   = 3'b100,
      ST_EXT    = 3'b101,
      ST_STOP   = 3'b110,
      ST_RECOV  = 3'b111
   } rxs_state_e;

   // prescale counter shape
   localparam int PS_STAGES = 12;
   localparam int SERVICE_LOW_BIT = 4;

   // reset and recovery timing, in fast-clock cycles
   localparam int LONG_CYCLES = 4096;
   localparam int PIN_LOW_CYCLES = 32;
   localparam int HOLD_CYCLES = 32;
   localparam int TAIL_CYCLES = 3;
   localparam int STOP_REC_LONG = 4096;
   localparam int STOP_REC_SHORT = 32;
   localparam int CNT_W = 7;

   // reset cause register bit positions and power-on value
   localparam int CAUSE_POR = 7;
   localparam int CAUSE_PIN = 6;
   localparam int CAUSE_WDOG = 5;
   localparam int CAUSE_BAD_OP = 4;
   localparam int CAUSE_BAD_ADDR = 3;
   localparam int CAUSE_LOW_V = 1;
   localparam logic [7:0] CAUSE_RESET = 8'h80;

   // reset vectors, user and monitor mode
   localparam logic [15:0] VEC_USER = 16'hFFFE;
   localparam logic [15:0] VEC_MON = 16'hFEFE;

   // interrupt selection codes
   localparam int INT_SEL_W = 4;
   localparam logic [INT_SEL_W-1:0] SEL_SWI = 4'h0;

   // bus clock divider width (fast clock / 4)
   localparam int BUS_DIV_W = 2;

endpackage : rxs_pkg

/* hw/rxs_prescaler.sv */
// rxs_prescaler: 12-stage prescale counter with overflow tick
`timescale 1ns/10ps
`default_nettype none

module rxs_prescaler
   import rxs_pkg::*;
#(
   parameter int STAGES = PS_STAGES
) (
   input wire logic i_clock,
   input wire logic i_reset,
   input wire logic i_clear,
   input wire logic i_service,
   output logic [STAGES-1:0] o_count,
   output logic o_tick
);

   typedef struct packed {
      logic [STAGES-1:0] count;
      logic tick;
   } rxs_ps_s;

   rxs_ps_s r;
   rxs_ps_s next_r;

   // count, overflow stage, clear and service
   always_comb begin
      next_r = r;
      next_r.tick = 1'b0;
      if (i_clear) begin
         next_r.count = '0;
      end else begin
         // overflow stage wraps the count and clocks the watchdog
         {next_r.tick, next_r.count} = {1'b0, r.count} + {{STAGES{1'b0}}, 1'b1};
         if (i_service) begin
            next_r.count[STAGES-1:SERVICE_LOW_BIT] = '0;
         end
      end
   end

   // state register
   always_ff @(posedge i_clock) begin
      if (i_reset) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign o_count = r.count;
   assign o_tick = r.tick;

   default clocking ps_cb @(posedge i_clock);
   endclocking
   default disable iff (i_reset);

   clear_zero_a: assert property (i_clear |=> o_count == '0)
      else $error("prescaler not cleared");
   service_top_a: assert property (
      i_service && !i_clear |=> o_count[STAGES-1:SERVICE_LOW_BIT] == '0)
      else $error("service left upper stages");
   tick_wrap_a: assert property (
      !i_clear && (&o_count) |=> o_tick && o_count == '0)
      else $error("overflow stage missing");

endmodule : rxs_prescaler

`default_nettype wire

/* hw/rxs_sequencer.sv */
// rxs_sequencer: reset sources, reset pin, prescaler, stop, interrupt latch
//
// How it works
// - any reset asserts internal reset, resets modules, selects reset vector
// - internal reset clears the prescaler; pin-only reset leaves it alone
// - pin held low long enough halts processing and sets pin cause
// - pin is a plain input unless reset pin enable is set
// - power-on and low-voltage resets drive pin low for 4096 + 32 cycles
// - internal resets drive pin low 32 cycles, then 35 more internal
// - recovery is 4163 cycles for power-on/low-voltage, 67 otherwise
// - power-on keeps clocks off 4096 cycles, sets power-on cause
// - watchdog overflow resets and sets watchdog cause
// - servicing clears watchdog and prescaler stages 12 to 5
// - prescaler tick clocks watchdog at least every 4080 cycles
// - watchdog halts in monitor break with break disable set
// - illegal opcode sets its cause and resets with pin low
// - stop with stop enable clear counts as illegal opcode
// - opcode fetch from unmapped space resets; data fetch does not
// - low voltage sets cause, holds pin until 4096 + 32 after recovery
// - twelve counting stages plus overflow stage clocking the watchdog
// - stop clears prescaler; wake recovery 32 or 4096 cycles
// - prescaler runs free once reset has ended
// - latched interrupt stays until serviced, mask cleared or internal reset
// - interrupts checked at instruction end, if unmasked and enabled
// - highest priority pending source served first, re-checked at each end with none latched
// - global mask blocks all sources except software interrupt
// - bus clock enable is one in four fast-clock cycles
`timescale 1ns/10ps
`default_nettype none

module rxs_sequencer
   import rxs_pkg::*;
#(
   parameter int PIN_MIN_CYCLES = 8,
   parameter int WD_BITS = 6,
   parameter int IRQ_COUNT = 6
) (
   input wire logic i_clock,
   input wire logic i_reset,
   input wire logic i_reset_pin_in,
   input wire logic i_reset_pin_enable,
   input wire logic i_low_voltage,
   input wire logic i_short_stop_recovery,
   input wire logic i_stop_enable,
   input wire logic i_monitor_mode,
   input wire logic i_break_active,
   input wire logic i_break_watchdog_disable,
   input wire logic i_watchdog_service,
   input wire logic i_illegal_opcode,
   input wire logic i_stop_exec,
   input wire logic i_opcode_fetch,
   input wire logic i_unmapped_access,
   input wire logic i_wake,
   input wire logic i_insn_done,
   input wire logic i_global_mask,
   input wire logic i_swi,
   input wire logic i_int_serviced,
   input wire logic [IRQ_COUNT-1:0] i_irq_pending,
   input wire logic [IRQ_COUNT-1:0] i_irq_enable,
   output logic o_reset_pin_out,
   output logic o_reset_pin_oe,
   output logic o_reset_pin_gpio,
   output logic o_internal_reset,
   output logic o_clocks_enable,
   output logic o_osc_enable,
   output logic o_bus_clock_en,
   output logic [15:0] o_reset_vector,
   output logic [7:0] o_reset_cause,
   output logic o_watchdog_tick,
   output logic o_stop_mode,
   output logic o_int_request,
   output logic [INT_SEL_W-1:0] o_int_select
);

   typedef struct packed {
      rxs_state_e st;
      logic [CNT_W-1:0] cnt;
      logic drive;
      logic [7:0] cause;
      logic [WD_BITS-1:0] wd;
      logic pin_s1;
      logic pin_s2;
      logic lv_s1;
      logic lv_s2;
      logic [7:0] pin_cnt;
      logic [BUS_DIV_W-1:0] bus_div;
      logic bus_en;
      logic int_valid;
      logic [INT_SEL_W-1:0] int_sel;
      logic mask_d;
   } rxs_seq_s;

   rxs_seq_s r;
   rxs_seq_s next_r;

   logic [PS_STAGES-1:0] ps_count;
   logic ps_tick;
   logic ps_clear;
   logic in_reset;
   logic wd_run;
   logic wd_over;
   logic bad_op_ev;
   logic bad_addr_ev;
   logic sw_ev;
   logic stop_ev;
   logic lv_ev;
   logic pin_low;
   logic ext_ev;
   logic rec_done;
   logic int_keep;
   logic [7:0] ev_cause;
   logic [IRQ_COUNT-1:0] irq_live;

   // lowest index wins: fixed priority, code is index plus one
   function automatic logic [INT_SEL_W-1:0] pick_source(
      input logic [IRQ_COUNT-1:0] live
   );
      logic [INT_SEL_W-1:0] sel;
      sel = SEL_SWI;
      for (int i = IRQ_COUNT - 1; i >= 0; i--) begin
         if (live[i]) begin
            sel = INT_SEL_W'(i + 1);
         end
      end
      return sel;
   endfunction : pick_source

   // prescale counter, also watchdog clock source
   rxs_prescaler #(
      .STAGES(PS_STAGES)
   ) u_prescaler (
      .i_clock(i_clock),
      .i_reset(i_reset),
      .i_clear(ps_clear),
      .i_service(i_watchdog_service),
      .o_count(ps_count),
      .o_tick(ps_tick)
   );

   // event decode
   assign in_reset = r.st inside {ST_LONG, ST_PINLOW, ST_HOLD, ST_TAIL, ST_EXT};
   assign wd_run = !(i_monitor_mode && i_break_active
      && i_break_watchdog_disable) && !in_reset;
   assign wd_over = wd_run && ps_tick && (&r.wd);
   assign bad_op_ev = i_illegal_opcode
      || (i_stop_exec && !i_stop_enable);
   assign bad_addr_ev = i_opcode_fetch && i_unmapped_access;
   assign sw_ev = (r.st == ST_RUN) && (bad_op_ev || bad_addr_ev);
   assign stop_ev = (r.st == ST_RUN) && i_stop_exec && i_stop_enable;
   assign lv_ev = r.lv_s2;
   assign pin_low = i_reset_pin_enable && !r.pin_s2 && !o_reset_pin_oe;
   assign ext_ev = pin_low && !in_reset
      && (r.pin_cnt == 8'(PIN_MIN_CYCLES - 1));
   assign irq_live = i_irq_pending & i_irq_enable;

   // stop recovery length chosen by short recovery bit
   assign rec_done = i_short_stop_recovery
      ? (ps_count == PS_STAGES'(STOP_REC_SHORT - 1))
      : (ps_count == PS_STAGES'(STOP_REC_LONG - 1));

   // prescaler clear: internal reset entry, low voltage, stop
   assign ps_clear = lv_ev
      || (!in_reset && (wd_over || sw_ev))
      || stop_ev || (r.st == ST_STOP);

   // cause bits of all sources firing this cycle, low voltage only outside ST_LONG
   always_comb begin
      ev_cause = '0;
      ev_cause[CAUSE_WDOG] = !in_reset && wd_over;
      ev_cause[CAUSE_BAD_OP] = sw_ev && bad_op_ev;
      ev_cause[CAUSE_BAD_ADDR] = sw_ev && bad_addr_ev;
      ev_cause[CAUSE_PIN] = ext_ev;
      ev_cause[CAUSE_LOW_V] = lv_ev && (r.st != ST_LONG);
   end

   // latched interrupt survives unless serviced, mask cleared or in internal reset
   assign int_keep = r.int_valid && !in_reset && !i_int_serviced
      && !(r.mask_d && !i_global_mask);

   // next state
   always_comb begin
      next_r = r;
      next_r.pin_s1 = i_reset_pin_in;
      next_r.pin_s2 = r.pin_s1;
      next_r.lv_s1 = i_low_voltage;
      next_r.lv_s2 = r.lv_s1;
      next_r.mask_d = i_global_mask;
      next_r.cnt = r.cnt + CNT_W'(1);
      // bus clock enable, one pulse every four cycles
      next_r.bus_div = r.bus_div + BUS_DIV_W'(1);
      next_r.bus_en = &r.bus_div;
      // watchdog counter
      if (in_reset || i_watchdog_service) begin
         next_r.wd = '0;
      end else if (wd_run && ps_tick) begin
         next_r.wd = r.wd + WD_BITS'(1);
      end
      // pin low filter
      if (pin_low && !in_reset) begin
         if (r.pin_cnt != 8'(PIN_MIN_CYCLES - 1)) begin
            next_r.pin_cnt = r.pin_cnt + 8'h01;
         end
      end else begin
         next_r.pin_cnt = '0;
      end
      // sequencer
      unique case (r.st)
         ST_RUN: begin
            if (stop_ev) begin
               next_r.st = ST_STOP;
            end
         end
         ST_LONG: begin
            if (!lv_ev && ps_count == PS_STAGES'(LONG_CYCLES - 1)) begin
               next_r.st = ST_PINLOW;
               next_r.drive = 1'b1;
               next_r.cnt = '0;
            end
         end
         ST_PINLOW: begin
            if (r.cnt == CNT_W'(PIN_LOW_CYCLES - 1)) begin
               next_r.st = ST_HOLD;
               next_r.cnt = '0;
            end
         end
         ST_HOLD: begin
            if (r.cnt == CNT_W'(HOLD_CYCLES - 1)) begin
               next_r.st = ST_TAIL;
               next_r.cnt = '0;
            end
         end
         ST_TAIL: begin
            if (r.cnt == CNT_W'(TAIL_CYCLES - 1)) begin
               next_r.st = ST_RUN;
               next_r.drive = 1'b0;
            end
         end
         ST_EXT: begin
            if (!pin_low) begin
               next_r.st = ST_PINLOW;
               next_r.drive = 1'b0;
               next_r.cnt = '0;
            end
         end
         ST_STOP: begin
            if (i_wake) begin
               next_r.st = ST_RECOV;
            end
         end
         ST_RECOV: begin
            if (rec_done) begin
               next_r.st = ST_RUN;
            end
         end
      endcase
      // reset sources override the state: low voltage in every state, pin and watchdog outside reset, faults in run only
      if (|ev_cause) begin
         next_r.cause = ev_cause;
      end
      if (!in_reset && (wd_over || sw_ev)) begin
         next_r.st = ST_PINLOW;
         next_r.drive = 1'b1;
         next_r.cnt = '0;
      end
      if (ext_ev) begin
         next_r.st = ST_EXT;
         next_r.drive = 1'b0;
      end
      if (lv_ev) begin
         next_r.st = ST_LONG;
         next_r.drive = 1'b0;
      end
      // interrupt latch, checked at instruction end only
      next_r.int_valid = int_keep;
      if (i_insn_done && !int_keep && !in_reset) begin
         if (i_swi) begin
            next_r.int_valid = 1'b1;
            next_r.int_sel = SEL_SWI;
         end else if (!i_global_mask && (|irq_live)) begin
            next_r.int_valid = 1'b1;
            next_r.int_sel = pick_source(irq_live);
         end
      end
   end

   // state register; power-up pulse starts the long sequence
   always_ff @(posedge i_clock) begin
      if (i_reset) begin
         r <= '0;
         r.st <= ST_LONG;
         r.cause <= CAUSE_RESET;
         r.pin_s1 <= 1'b1;
         r.pin_s2 <= 1'b1;
      end else begin
         r <= next_r;
      end
   end

   // outputs
   assign o_reset_pin_out = 1'b0;
   assign o_reset_pin_oe = i_reset_pin_enable && ((r.st == ST_LONG)
      || (r.st == ST_PINLOW && r.drive));
   assign o_reset_pin_gpio = r.pin_s2;
   assign o_internal_reset = in_reset;
   assign o_clocks_enable = !(r.st inside {ST_LONG, ST_STOP, ST_RECOV});
   assign o_osc_enable = (r.st != ST_STOP);
   assign o_bus_clock_en = r.bus_en && o_clocks_enable;
   assign o_reset_vector = i_monitor_mode ? VEC_MON : VEC_USER;
   assign o_reset_cause = r.cause;
   assign o_watchdog_tick = ps_tick;
   assign o_stop_mode = (r.st == ST_STOP) || (r.st == ST_RECOV);
   assign o_int_request = r.int_valid;
   assign o_int_select = r.int_sel;

   default clocking seq_cb @(posedge i_clock);
   endclocking
   default disable iff (i_reset);

   sequence short_entry;
      r.st == ST_RUN ##1 r.st == ST_PINLOW && r.drive;
   endsequence

   sequence long_exit;
      r.st == ST_LONG ##1 r.st == ST_PINLOW;
   endsequence

   sw_reset_a: assert property (
      sw_ev |=> o_internal_reset ##1 r.wd == '0)
      else $error("software fault did not reset");
   ext_keep_a: assert property (r.st == ST_EXT && !lv_ev |-> !ps_clear)
      else $error("pin reset cleared prescaler");
   pin_cause_a: assert property (
      ext_ev && !lv_ev |=> r.st == ST_EXT && o_reset_cause[CAUSE_PIN])
      else $error("pin reset not recorded");
   pin_gpio_a: assert property (!i_reset_pin_enable |-> !o_reset_pin_oe)
      else $error("pin driven while disabled");
   long_drive_a: assert property (
      r.st == ST_LONG && i_reset_pin_enable |-> o_reset_pin_oe)
      else $error("pin not low in long reset");
   long_len_a: assert property (
      long_exit |-> $past(ps_count) == PS_STAGES'(LONG_CYCLES - 1))
      else $error("long reset wrong length");
   short_len_a: assert property (
      short_entry ##0 !lv_ev [*8] |-> ##25 r.st == ST_HOLD)
      else $error("pin low phase wrong length");
   recov_len_a: assert property (
      short_entry |-> ##66 r.st == ST_TAIL || lv_ev || $past(lv_ev))
      else $error("short recovery wrong length");
   clk_hold_a: assert property (
      r.st == ST_LONG |-> !o_clocks_enable && o_internal_reset)
      else $error("clocks ran in long reset");
   wd_cause_a: assert property (
      wd_over && !lv_ev && !ext_ev |=> r.st == ST_PINLOW
      && o_reset_cause[CAUSE_WDOG])
      else $error("watchdog overflow not reset");
   wd_serv_a: assert property (i_watchdog_service |=> r.wd == '0)
      else $error("service did not clear watchdog");
   wd_break_a: assert property (
      !wd_run && !in_reset && !i_watchdog_service |=> $stable(r.wd))
      else $error("watchdog ran in break");
   bad_op_a: assert property (
      sw_ev && bad_op_ev && !lv_ev && !ext_ev |=> r.st == ST_PINLOW
      && o_reset_cause[CAUSE_BAD_OP] && r.drive)
      else $error("illegal opcode not reset");
   data_fetch_a: assert property (
      r.st == ST_RUN && i_unmapped_access && !i_opcode_fetch && !bad_op_ev
      && !wd_over && !ext_ev && !lv_ev |=> r.st != ST_PINLOW)
      else $error("data fetch caused reset");
   lv_a: assert property (
      lv_ev |=> r.st == ST_LONG && ps_count == '0)
      else $error("low voltage not held");
   stop_clr_a: assert property (r.st == ST_STOP |=> ps_count == '0)
      else $error("prescaler ran in stop");
   latch_a: assert property (
      int_keep |=> o_int_request && $stable(o_int_select))
      else $error("latched interrupt replaced");
   mask_a: assert property (
      !r.int_valid ##1 o_int_request && o_int_select != SEL_SWI
      |-> $past(!i_global_mask && i_insn_done))
      else $error("masked interrupt taken");
   bus_en_a: assert property (o_bus_clock_en |=> !o_bus_clock_en [*3])
      else $error("bus enable too dense");

endmodule : rxs_sequencer

`default_nettype wire

/* tb/rxs_far_side.sv */
// rxs_far_side: reset pin with pull-up and a watchdog service writer
`timescale 1ns/10ps
`default_nettype none

module rxs_far_side (
   input wire logic i_clock,
   input wire logic i_pin_oe,
   input wire logic i_pull_low,
   input wire logic i_service_req,
   output logic o_pin_level,
   output logic o_service
);
   logic want = 1'b0;

   // open drain: either party pulls low, the pull-up wins otherwise
   assign o_pin_level = (i_pin_oe || i_pull_low) ? 1'b0 : 1'b1;

   // request taken at the rising edge, write shown after the falling one
   always @(posedge i_clock) begin
      want <= i_service_req;
   end
   initial o_service = 1'b0;
   always @(negedge i_clock) begin
      o_service <= want;
   end
endmodule : rxs_far_side
`default_nettype wire

/* tb/reset_and_exception_sequencer_tb.sv */
// reset_and_exception_sequencer_tb: self-checking bench for rxs_sequencer
`timescale 1ns/10ps
`default_nettype none

module reset_and_exception_sequencer_tb;
   import rxs_pkg::*;
   logic i_clock = 1'b0;
   logic i_reset = 1'b1;
   logic pin_in, pin_en = 1'b1, lv = 1'b0, short_rec = 1'b0, stop_en = 1'b1;
   logic mon = 1'b0, brk = 1'b0, brk_dis = 1'b0, wd_svc, ill_op = 1'b0;
   logic stop_x = 1'b0, op_f = 1'b0, unmap = 1'b0, wake = 1'b0, done = 1'b0;
   logic mask = 1'b0, swi = 1'b0, serviced = 1'b0;
   logic pull_low = 1'b0, svc_req = 1'b0;
   logic [5:0] pend = 6'h00, ena = 6'h00;
   logic pin_out, pin_oe, pin_gpio, int_rst, clk_en, osc_en, bus_en;
   logic wd_tick, stop_mode, int_req;
   logic [15:0] vec;
   logic [7:0] cause;
   logic [INT_SEL_W-1:0] sel;
   int miscompares = 0;
   int comparisons = 0;
   int cycles = 0;
   int oe_cnt = 0;

   // fast clock, 4 ns period
   initial forever #2 i_clock = ~i_clock;

   rxs_sequencer #(.PIN_MIN_CYCLES(2), .WD_BITS(2), .IRQ_COUNT(6)) u_dut (
      .i_clock(i_clock), .i_reset(i_reset), .i_reset_pin_in(pin_in),
      .i_reset_pin_enable(pin_en), .i_low_voltage(lv),
      .i_short_stop_recovery(short_rec), .i_stop_enable(stop_en),
      .i_monitor_mode(mon), .i_break_active(brk),
      .i_break_watchdog_disable(brk_dis), .i_watchdog_service(wd_svc),
      .i_illegal_opcode(ill_op), .i_stop_exec(stop_x), .i_opcode_fetch(op_f),
      .i_unmapped_access(unmap), .i_wake(wake), .i_insn_done(done),
      .i_global_mask(mask), .i_swi(swi), .i_int_serviced(serviced),
      .i_irq_pending(pend), .i_irq_enable(ena), .o_reset_pin_out(pin_out),
      .o_reset_pin_oe(pin_oe), .o_reset_pin_gpio(pin_gpio),
      .o_internal_reset(int_rst), .o_clocks_enable(clk_en),
      .o_osc_enable(osc_en), .o_bus_clock_en(bus_en), .o_reset_vector(vec),
      .o_reset_cause(cause), .o_watchdog_tick(wd_tick),
      .o_stop_mode(stop_mode), .o_int_request(int_req), .o_int_select(sel)
   );

   rxs_far_side u_far (
      .i_clock(i_clock), .i_pin_oe(pin_oe), .i_pull_low(pull_low),
      .i_service_req(svc_req), .o_pin_level(pin_in), .o_service(wd_svc)
   );

   task automatic final_report();
      $display("counts: %0d comparisons, %0d miscompares", comparisons,
               miscompares);
      if (miscompares == 0 && comparisons > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : final_report

   // cycle count for the hang limit, pin-drive cycles before each edge
   always @(posedge i_clock) begin
      cycles++;
      if (pin_oe === 1'b1) oe_cnt++;
      if (cycles == 90000) begin
         miscompares++;
         final_report();
      end
   end

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         miscompares++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic step(input int k);
      repeat (k) @(negedge i_clock);
   endtask : step

   // falling-edge cycles for which internal reset stays high
   task automatic count_rst(output int n);
      n = 0;
      while (int_rst === 1'b1 && n < 9000) begin
         step(1);
         n++;
      end
   endtask : count_rst

   task automatic wait_tick(output int n);
      n = 0;
      do begin
         step(1);
         n++;
      end while (wd_tick !== 1'b1 && n < 6000);
   endtask : wait_tick

   task automatic t_power_on();
      int n;
      step(20);
      i_reset = 1'b0;
      chk(cause, 16'h0080);
      chk(clk_en, 16'h0000);
      count_rst(n);
      chk(n, 16'd4163);
      chk(clk_en, 16'h0001);
      chk(vec, 16'hfffe);
      mon = 1'b1;
      step(1);
      chk(vec, 16'hfefe);
      mon = 1'b0;
      n = 0;
      repeat (40) begin
         step(1);
         if (bus_en === 1'b1) n++;
      end
      chk(n, 16'd10);
      $display("test power_on done");
   endtask : t_power_on

   task automatic t_irq();
      pend = 6'h14;
      ena = 6'h3c;
      done = 1'b1;
      step(1);
      done = 1'b0;
      chk({int_req, 11'h0, sel}, 16'h8003);
      pend = 6'h01;
      ena = 6'h3f;
      done = 1'b1;
      step(1);
      done = 1'b0;
      chk({int_req, 11'h0, sel}, 16'h8003);
      serviced = 1'b1;
      step(1);
      serviced = 1'b0;
      chk(int_req, 16'h0000);
      done = 1'b1;
      step(1);
      chk({int_req, 11'h0, sel}, 16'h8001);
      done = 1'b0;
      serviced = 1'b1;
      step(1);
      serviced = 1'b0;
      mask = 1'b1;
      done = 1'b1;
      step(1);
      done = 1'b0;
      chk(int_req, 16'h0000);
      swi = 1'b1;
      done = 1'b1;
      step(1);
      done = 1'b0;
      swi = 1'b0;
      chk({int_req, 11'h0, sel}, 16'h8000);
      mask = 1'b0;
      step(1);
      chk(int_req, 16'h0000);
      ena = 6'h00;
      done = 1'b1;
      step(1);
      done = 1'b0;
      pend = 6'h00;
      chk(int_req, 16'h0000);
      $display("test interrupts done");
   endtask : t_irq

   task automatic t_faults();
      int n;
      ill_op = 1'b1;
      oe_cnt = 0;
      step(1);
      ill_op = 1'b0;
      count_rst(n);
      chk(n, 16'd67);
      chk(oe_cnt, 16'd32);
      chk(cause, 16'h0010);
      unmap = 1'b1;
      step(1);
      unmap = 1'b0;
      step(3);
      chk(int_rst, 16'h0000);
      op_f = 1'b1;
      unmap = 1'b1;
      step(1);
      op_f = 1'b0;
      unmap = 1'b0;
      count_rst(n);
      chk(n, 16'd67);
      chk(cause, 16'h0008);
      stop_en = 1'b0;
      stop_x = 1'b1;
      step(1);
      stop_x = 1'b0;
      count_rst(n);
      stop_en = 1'b1;
      chk(cause, 16'h0010);
      $display("test faults done");
   endtask : t_faults

   task automatic t_stop();
      int n;
      int exp;
      for (int s = 1; s >= 0; s--) begin
         short_rec = s[0];
         exp = (s == 1) ? 32 : 4096;
         stop_x = 1'b1;
         step(1);
         stop_x = 1'b0;
         chk({stop_mode, osc_en}, 16'h0002);
         step(5);
         wake = 1'b1;
         step(1);
         wake = 1'b0;
         n = 0;
         while (stop_mode === 1'b1 && n < 5000) begin
            step(1);
            n++;
         end
         chk(16'(n >= exp - 1 && n <= exp + 3), 16'h0001);
         chk({int_rst, osc_en}, 16'h0001);
      end
      $display("test stop done");
   endtask : t_stop

   task automatic t_pin();
      int n;
      pin_en = 1'b0;
      pull_low = 1'b1;
      step(10);
      chk({int_rst, pin_gpio}, 16'h0000);
      pull_low = 1'b0;
      step(3);
      pin_en = 1'b1;
      oe_cnt = 0;
      pull_low = 1'b1;
      step(10);
      chk(int_rst, 16'h0001);
      pull_low = 1'b0;
      count_rst(n);
      chk(16'(n >= 67 && n <= 70), 16'h0001);
      chk(oe_cnt, 16'h0000);
      chk(cause, 16'h0040);
      $display("test pin done");
   endtask : t_pin

   task automatic t_low_voltage();
      int n;
      lv = 1'b1;
      step(50);
      chk({int_rst, pin_oe, pin_out}, 16'h0006);
      chk(cause, 16'h0002);
      lv = 1'b0;
      count_rst(n);
      chk(16'(n >= 4163 && n <= 4167), 16'h0001);
      $display("test low_voltage done");
   endtask : t_low_voltage

   task automatic t_watchdog();
      int n;
      wait_tick(n);
      wait_tick(n);
      chk(n, 16'd4096);
      step(1000);
      svc_req = 1'b1;
      step(1);
      svc_req = 1'b0;
      wait_tick(n);
      chk(16'(n >= 4080 && n <= 4098), 16'h0001);
      mon = 1'b1;
      brk = 1'b1;
      brk_dis = 1'b1;
      step(16500);
      chk({int_rst, cause}, 16'h0002);
      mon = 1'b0;
      brk = 1'b0;
      brk_dis = 1'b0;
      n = 0;
      while (int_rst !== 1'b1 && n < 20000) begin
         step(1);
         n++;
      end
      chk({int_rst, cause}, 16'h0120);
      count_rst(n);
      $display("test watchdog done");
   endtask : t_watchdog

   // main sequence
   initial begin
      t_power_on();
      t_irq();
      t_faults();
      t_stop();
      t_pin();
      t_low_voltage();
      t_watchdog();
      final_report();
   end
endmodule : reset_and_exception_sequencer_tb
`default_nettype wire
